// ===== logic/level_mute_tieoff_pkg.sv
// Shared constants for the level readout, automute and tie-off register slice.
package level_mute_tieoff_pkg;

	// Register width and register addresses on the control port.
	localparam int          REG_WIDTH          = 9;
	localparam int          ADDR_WIDTH         = 7;
	localparam logic [6:0]  ADDR_PP_LEVEL      = 7'h4c;
	localparam logic [6:0]  ADDR_PEAK_LEVEL    = 7'h4d;
	localparam logic [6:0]  ADDR_AUTOMUTE      = 7'h4e;
	localparam logic [6:0]  ADDR_TIEOFF        = 7'h4f;

	// Reset values.
	localparam logic [8:0]  RESET_PP_LEVEL     = 9'h000;
	localparam logic [8:0]  RESET_PEAK_LEVEL   = 9'h000;
	localparam logic [8:0]  RESET_AUTOMUTE     = 9'h000;
	localparam logic [8:0]  RESET_TIEOFF       = 9'h000;

	// Automute control and status field positions.
	localparam int          BIT_LIMITER_OVER   = 0;
	localparam int          BIT_GAIN_ZERO      = 2;
	localparam int          BIT_AUTOMUTE_ACT   = 3;
	localparam int          BIT_NOISE_GATE     = 4;
	localparam int          BIT_SUPPLY_HIGH    = 5;
	localparam int          BIT_TAP_SELECT     = 6;

	// Tie-off override field positions.
	localparam int          BIT_LINE_TIEOFF    = 3;
	localparam int          BIT_SPK_POS_TIEOFF = 4;
	localparam int          BIT_SPK_NEG_TIEOFF = 5;
	localparam int          BIT_UNITY_BYPASS   = 6;
	localparam int          BIT_BOOST_BYPASS   = 7;
	localparam int          BIT_OVERRIDE_EN    = 8;

	// Writable masks of the two control registers.
	localparam logic [8:0]  MASK_AUTOMUTE_WR   = 9'h040;
	localparam logic [8:0]  MASK_TIEOFF_WR     = 9'h1f8;

	// Serial frame lengths and the position of the read flag.
	localparam logic [4:0]  FRAME_SHORT_BITS   = 5'h10;
	localparam logic [4:0]  FRAME_LONG_BITS    = 5'h18;
	localparam logic [4:0]  HEADER_BITS        = 5'h08;
	localparam logic [4:0]  COUNT_MAX          = 5'h1f;
	localparam int          READ_WORD_BITS     = 16;

	// Number of synchronised status inputs.
	localparam int          STATUS_COUNT       = 5;

endpackage

// ===== logic/status_sync.sv
// Two flip-flop synchroniser for a group of independent status levels.
`timescale 1ns/100ps
module status_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_reg;

	// Elaboration check: an empty group has nothing to carry.
	if (WIDTH < 1) begin : g_width_check
		$error("status_sync needs at least one bit");
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_o   <= '0;
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end

endmodule

// ===== logic/level_mute_tieoff_regs.sv
// Level readouts, automute control and status, and tie-off override registers.
`timescale 1ns/100ps
module level_mute_tieoff_regs (
	input  wire logic       CLK_SYS_I,
	input  wire logic       RST_I,
	// Serial control port, sampled on the system clock.
	input  wire logic       MODE_I,
	input  wire logic       FORCE_FOUR_WIRE_PORT_I,
	input  wire logic       PORT_SELECT_N_I,
	input  wire logic       SCLK_I,
	input  wire logic       SDIO_I,
	output logic            SDIO_O,
	output logic            SDIO_OE_O,
	// Detector values from the level-control logic.
	input  wire logic       DUAL_CHANNEL_I,
	input  wire logic [8:0] PP_AMPLITUDE_LEFT_I,
	input  wire logic [8:0] PP_AMPLITUDE_RIGHT_I,
	input  wire logic [8:0] PEAK_AMPLITUDE_LEFT_I,
	input  wire logic [8:0] PEAK_AMPLITUDE_RIGHT_I,
	// Status levels from the limiter, mute, gate and supply detector.
	input  wire logic       LIMITER_OVER_I,
	input  wire logic       DIGITAL_GAIN_ZERO_I,
	input  wire logic       AUTOMUTE_ACTIVE_I,
	input  wire logic       NOISE_GATE_HOLD_I,
	input  wire logic       SPEAKER_SUPPLY_HIGH_I,
	// Automatic switch requests from the output control logic.
	input  wire logic       AUTO_LINE_TIEOFF_I,
	input  wire logic       AUTO_SPK_POS_TIEOFF_I,
	input  wire logic       AUTO_SPK_NEG_TIEOFF_I,
	input  wire logic       AUTO_UNITY_BYPASS_I,
	input  wire logic       AUTO_BOOST_BYPASS_I,
	input  wire logic       UNITY_BUFFER_OFF_I,
	input  wire logic       BOOST_BUFFER_OFF_I,
	// Switch controls toward the analog outputs, 1 is closed.
	output logic            AUTOMUTE_TAP_SELECT_O,
	output logic            LINE_TIEOFF_CLOSE_O,
	output logic            SPK_POS_TIEOFF_CLOSE_O,
	output logic            SPK_NEG_TIEOFF_CLOSE_O,
	output logic            UNITY_BYPASS_CLOSE_O,
	output logic            BOOST_BYPASS_CLOSE_O
);

	localparam int SC = level_mute_tieoff_pkg::STATUS_COUNT;
	// Read words leave the port most significant bit first.
	localparam int READ_MSB = level_mute_tieoff_pkg::READ_WORD_BITS - 1;

	typedef enum logic [1:0] {
		PORT_IDLE,
		PORT_SHIFT,
		PORT_READ
	} port_state_t;

	port_state_t state_reg;
	port_state_t state_next;

	logic [8:0]  pp_level_reg;
	logic [8:0]  peak_level_reg;
	logic [8:0]  automute_ctrl_reg;
	logic [8:0]  tieoff_reg;

	logic [SC-1:0] status_raw;
	logic [SC-1:0] status_sync;

	logic        sclk_prev_reg;
	logic        sel_prev_reg;
	logic [4:0]  count_reg;
	logic [23:0] shift_reg;
	logic [15:0] tx_reg;
	logic        long_frame_reg;

	logic        sclk_rise;
	logic        sclk_fall;
	logic        sel_start;
	logic        sel_end;
	logic        port_enabled;
	logic        write_strobe;
	logic [6:0]  write_addr;
	logic [8:0]  write_data;
	logic [8:0]  read_data;
	logic [8:0]  status_word;

	// Status levels come from other clock domains and analog comparators.
	assign status_raw = {SPEAKER_SUPPLY_HIGH_I, NOISE_GATE_HOLD_I, AUTOMUTE_ACTIVE_I,
		DIGITAL_GAIN_ZERO_I, LIMITER_OVER_I};

	status_sync #(
		.WIDTH (SC)
	) u_status_sync (
		.clk_i   (CLK_SYS_I),
		.rst_i   (RST_I),
		.async_i (status_raw),
		.sync_o  (status_sync)
	);

	// Detector readouts follow the level-control values every cycle.
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			pp_level_reg <= level_mute_tieoff_pkg::RESET_PP_LEVEL;
		end else if (DUAL_CHANNEL_I && (PP_AMPLITUDE_RIGHT_I > PP_AMPLITUDE_LEFT_I)) begin
			pp_level_reg <= PP_AMPLITUDE_RIGHT_I;
		end else begin
			pp_level_reg <= PP_AMPLITUDE_LEFT_I;
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			peak_level_reg <= level_mute_tieoff_pkg::RESET_PEAK_LEVEL;
		end else if (DUAL_CHANNEL_I && (PEAK_AMPLITUDE_RIGHT_I > PEAK_AMPLITUDE_LEFT_I)) begin
			peak_level_reg <= PEAK_AMPLITUDE_RIGHT_I;
		end else begin
			peak_level_reg <= PEAK_AMPLITUDE_LEFT_I;
		end
	end

	// Status bits are read live from the synchronised levels.
	always_comb begin
		status_word = 9'h000;
		status_word[level_mute_tieoff_pkg::BIT_LIMITER_OVER] = status_sync[0];
		status_word[level_mute_tieoff_pkg::BIT_GAIN_ZERO]    = status_sync[1];
		status_word[level_mute_tieoff_pkg::BIT_AUTOMUTE_ACT] = status_sync[2];
		status_word[level_mute_tieoff_pkg::BIT_NOISE_GATE]   = status_sync[3];
		status_word[level_mute_tieoff_pkg::BIT_SUPPLY_HIGH]  = status_sync[4];
		status_word[level_mute_tieoff_pkg::BIT_TAP_SELECT]   =
			automute_ctrl_reg[level_mute_tieoff_pkg::BIT_TAP_SELECT];
	end

	// Port edge detection; the pins are synchronous to the system clock.
	// Both previous levels reset to the idle levels of their pins, so reset makes no false edge.
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			sclk_prev_reg <= 1'b0;
			sel_prev_reg  <= 1'b1;
		end else begin
			sclk_prev_reg <= SCLK_I;
			sel_prev_reg  <= PORT_SELECT_N_I;
		end
	end

	assign sclk_rise    = SCLK_I && !sclk_prev_reg;
	assign sclk_fall    = !SCLK_I && sclk_prev_reg;
	assign sel_start    = !PORT_SELECT_N_I && sel_prev_reg;
	assign sel_end      = PORT_SELECT_N_I && !sel_prev_reg;
	// The two-wire mode is served elsewhere; this port only listens in serial modes.
	assign port_enabled = MODE_I || FORCE_FOUR_WIRE_PORT_I;

	// A read is recognised on the eighth rise when the read flag comes in high.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PORT_IDLE: begin
				if (sel_start && port_enabled) begin
					state_next = PORT_SHIFT;
				end
			end
			PORT_SHIFT: begin
				if (sel_end) begin
					state_next = PORT_IDLE;
				end else if (sclk_rise && long_frame_reg
					&& (count_reg == level_mute_tieoff_pkg::HEADER_BITS - 5'h01)
					&& SDIO_I) begin
					state_next = PORT_READ;
				end
			end
			PORT_READ: begin
				if (sel_end) begin
					state_next = PORT_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			state_reg <= PORT_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Frame length is latched when the frame opens.
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			long_frame_reg <= 1'b0;
		end else if (state_reg == PORT_IDLE && sel_start) begin
			long_frame_reg <= FORCE_FOUR_WIRE_PORT_I;
		end
	end

	// Bits are captured on SCLK rising edges, most significant first.
	// The count saturates so an overlong frame cannot wrap back to a legal length.
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			count_reg <= 5'h00;
			shift_reg <= 24'h000000;
		end else if (state_reg == PORT_IDLE) begin
			count_reg <= 5'h00;
		end else if (sclk_rise) begin
			shift_reg <= {shift_reg[22:0], SDIO_I};
			if (count_reg != level_mute_tieoff_pkg::COUNT_MAX) begin
				count_reg <= count_reg + 5'h01;
			end
		end
	end

	// A write lands when select rises after exactly a full frame.
	// Frames of any other length are dropped without notice.
	always_comb begin
		write_strobe = 1'b0;
		write_addr   = 7'h00;
		write_data   = 9'h000;
		if (state_reg == PORT_SHIFT && sel_end) begin
			if (long_frame_reg) begin
				write_strobe = (count_reg == level_mute_tieoff_pkg::FRAME_LONG_BITS);
				write_addr   = shift_reg[23:17];
				write_data   = shift_reg[8:0];
			end else begin
				write_strobe = (count_reg == level_mute_tieoff_pkg::FRAME_SHORT_BITS);
				write_addr   = shift_reg[15:9];
				write_data   = shift_reg[8:0];
			end
		end
	end

	// Only the tap select bit is writable in the automute register.
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			automute_ctrl_reg <= level_mute_tieoff_pkg::RESET_AUTOMUTE;
		end else if (write_strobe && write_addr == level_mute_tieoff_pkg::ADDR_AUTOMUTE) begin
			automute_ctrl_reg <= write_data & level_mute_tieoff_pkg::MASK_AUTOMUTE_WR;
		end
	end

	// Bits 2:0 of the override register are not implemented and read as zero.
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			tieoff_reg <= level_mute_tieoff_pkg::RESET_TIEOFF;
		end else if (write_strobe && write_addr == level_mute_tieoff_pkg::ADDR_TIEOFF) begin
			tieoff_reg <= write_data & level_mute_tieoff_pkg::MASK_TIEOFF_WR;
		end
	end

	// Read data for the long-frame read; unmapped addresses read zero.
	always_comb begin
		unique case (shift_reg[7:1])
			level_mute_tieoff_pkg::ADDR_PP_LEVEL:   read_data = pp_level_reg;
			level_mute_tieoff_pkg::ADDR_PEAK_LEVEL: read_data = peak_level_reg;
			level_mute_tieoff_pkg::ADDR_AUTOMUTE:   read_data = status_word;
			level_mute_tieoff_pkg::ADDR_TIEOFF:     read_data = tieoff_reg;
			default:                                read_data = 9'h000;
		endcase
	end

	// Read word is loaded after the header and shifted out on SCLK falling edges.
	// The address stays in the low shift bits until the ninth rise, so the load waits there.
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			tx_reg <= 16'h0000;
		end else if (state_reg == PORT_SHIFT && state_next == PORT_READ) begin
			tx_reg <= 16'h0000;
		end else if (state_reg == PORT_READ && sclk_fall
			&& count_reg > level_mute_tieoff_pkg::HEADER_BITS) begin
			tx_reg <= {tx_reg[14:0], 1'b0};
		end else if (state_reg == PORT_READ && count_reg == level_mute_tieoff_pkg::HEADER_BITS
			&& !sclk_fall && tx_reg == 16'h0000) begin
			tx_reg <= {7'h00, read_data};
		end
	end

	// Registered pad controls keep the data line free of decode glitches.
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			SDIO_O    <= 1'b0;
			SDIO_OE_O <= 1'b0;
		end else begin
			SDIO_O    <= (state_next == PORT_READ) ? tx_reg[READ_MSB] : 1'b0;
			SDIO_OE_O <= (state_next == PORT_READ);
		end
	end

	// Switch controls toward the analog block, registered.
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			AUTOMUTE_TAP_SELECT_O <= 1'b0;
		end else begin
			AUTOMUTE_TAP_SELECT_O <= automute_ctrl_reg[level_mute_tieoff_pkg::BIT_TAP_SELECT];
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			LINE_TIEOFF_CLOSE_O    <= 1'b0;
			SPK_POS_TIEOFF_CLOSE_O <= 1'b0;
			SPK_NEG_TIEOFF_CLOSE_O <= 1'b0;
		end else if (tieoff_reg[level_mute_tieoff_pkg::BIT_OVERRIDE_EN]) begin
			LINE_TIEOFF_CLOSE_O    <= tieoff_reg[level_mute_tieoff_pkg::BIT_LINE_TIEOFF];
			SPK_POS_TIEOFF_CLOSE_O <= tieoff_reg[level_mute_tieoff_pkg::BIT_SPK_POS_TIEOFF];
			SPK_NEG_TIEOFF_CLOSE_O <= tieoff_reg[level_mute_tieoff_pkg::BIT_SPK_NEG_TIEOFF];
		end else begin
			LINE_TIEOFF_CLOSE_O    <= AUTO_LINE_TIEOFF_I;
			SPK_POS_TIEOFF_CLOSE_O <= AUTO_SPK_POS_TIEOFF_I;
			SPK_NEG_TIEOFF_CLOSE_O <= AUTO_SPK_NEG_TIEOFF_I;
		end
	end

	// A forced bypass only closes while its buffer is off; otherwise automatic control holds.
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			UNITY_BYPASS_CLOSE_O <= 1'b0;
			BOOST_BYPASS_CLOSE_O <= 1'b0;
		end else begin
			UNITY_BYPASS_CLOSE_O <= AUTO_UNITY_BYPASS_I
				|| (tieoff_reg[level_mute_tieoff_pkg::BIT_OVERRIDE_EN]
				&& tieoff_reg[level_mute_tieoff_pkg::BIT_UNITY_BYPASS]
				&& UNITY_BUFFER_OFF_I);
			BOOST_BYPASS_CLOSE_O <= AUTO_BOOST_BYPASS_I
				|| (tieoff_reg[level_mute_tieoff_pkg::BIT_OVERRIDE_EN]
				&& tieoff_reg[level_mute_tieoff_pkg::BIT_BOOST_BYPASS]
				&& BOOST_BUFFER_OFF_I);
		end
	end

endmodule

// ===== sim/level_mute_tieoff_assertions.sv
// Checker for the serial read path and the tap, line and bypass switch outputs of the register slice.
`timescale 1ns/100ps
module level_mute_tieoff_checker (
	input  wire logic CLK_SYS_I,
	input  wire logic RST_I,
	input  wire logic FORCE_FOUR_WIRE_PORT_I,
	input  wire logic PORT_SELECT_N_I,
	input  wire logic SDIO_O,
	input  wire logic SDIO_OE_O,
	input  wire logic AUTO_LINE_TIEOFF_I,
	input  wire logic AUTO_UNITY_BYPASS_I,
	input  wire logic AUTO_BOOST_BYPASS_I,
	input  wire logic UNITY_BUFFER_OFF_I,
	input  wire logic BOOST_BUFFER_OFF_I,
	input  wire logic AUTOMUTE_TAP_SELECT_O,
	input  wire logic LINE_TIEOFF_CLOSE_O,
	input  wire logic UNITY_BYPASS_CLOSE_O,
	input  wire logic BOOST_BYPASS_CLOSE_O
);
	default clocking @(posedge CLK_SYS_I);
	endclocking
	default disable iff (RST_I);

	a_oe_in_frame: assert property (
		SDIO_OE_O |-> !$past(PORT_SELECT_N_I, 2) && $past(FORCE_FOUR_WIRE_PORT_I))
		else $error("read enable outside a long frame");
	a_sdio_quiet: assert property (
		!SDIO_OE_O |-> !SDIO_O)
		else $error("read data driven while disabled");
	a_unity_auto: assert property (AUTO_UNITY_BYPASS_I |=> UNITY_BYPASS_CLOSE_O)
		else $error("unity bypass ignores automatic request");
	a_boost_auto: assert property (AUTO_BOOST_BYPASS_I |=> BOOST_BYPASS_CLOSE_O)
		else $error("boost bypass ignores automatic request");
	a_unity_cause: assert property (
		UNITY_BYPASS_CLOSE_O |-> $past(AUTO_UNITY_BYPASS_I || UNITY_BUFFER_OFF_I))
		else $error("unity bypass closed without cause");
	a_boost_cause: assert property (
		BOOST_BYPASS_CLOSE_O |-> $past(AUTO_BOOST_BYPASS_I || BOOST_BUFFER_OFF_I))
		else $error("boost bypass closed without cause");
	a_line_cause: assert property (
		$changed(LINE_TIEOFF_CLOSE_O) |-> $past(RST_I, 2)
		|| $past(AUTO_LINE_TIEOFF_I) != $past(AUTO_LINE_TIEOFF_I, 2)
		|| $past(PORT_SELECT_N_I, 2) && !$past(PORT_SELECT_N_I, 3))
		else $error("line switch moved without cause");
	a_tap_write: assert property (
		$changed(AUTOMUTE_TAP_SELECT_O) |-> $past(PORT_SELECT_N_I) && !$past(PORT_SELECT_N_I, 3))
		else $error("tap select moved outside a write");
endmodule

bind level_mute_tieoff_regs level_mute_tieoff_checker u_chk (.CLK_SYS_I, .RST_I,
	.FORCE_FOUR_WIRE_PORT_I, .PORT_SELECT_N_I, .SDIO_O, .SDIO_OE_O, .AUTO_LINE_TIEOFF_I,
	.AUTO_UNITY_BYPASS_I, .AUTO_BOOST_BYPASS_I, .UNITY_BUFFER_OFF_I, .BOOST_BUFFER_OFF_I,
	.AUTOMUTE_TAP_SELECT_O, .LINE_TIEOFF_CLOSE_O, .UNITY_BYPASS_CLOSE_O, .BOOST_BYPASS_CLOSE_O);

// ===== sim/serial_host.sv
// Host model that frames serial writes and reads toward the register slice.
`timescale 1ns/100ps
module serial_host (
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      sel_n_o,
	output logic      sclk_o,
	output logic      sdio_o
);
	initial begin
		sel_n_o = 1'b1;
		sclk_o = 1'b0;
		sdio_o = 1'b0;
	end

	// Sends the low n bits of v MSB first; samples the wire before each of the last 16 rises.
	task automatic xfer(input logic [23:0] v, input int n, output logic [15:0] q);
		q = 16'h0000;
		sel_n_o <= 1'b0;
		repeat (2) @(negedge clk_i);
		for (int i = n - 1; i >= 0; i--) begin
			sdio_o <= v[i];
			sclk_o <= 1'b0;
			repeat (3) @(negedge clk_i);
			if (i < 16)
				q = {q[14:0], line_i};
			sclk_o <= 1'b1;
			repeat (2) @(negedge clk_i);
		end
		sclk_o <= 1'b0;
		@(negedge clk_i);
		sel_n_o <= 1'b1;
		// A released line no longer shows the last bit.
		sdio_o <= ~sdio_o;
		repeat (3) @(negedge clk_i);
	endtask

	task automatic wr16(input logic [6:0] a, input logic [8:0] d);
		logic [15:0] q;
		xfer({8'h00, a, d}, 16, q);
	endtask

	task automatic wr24(input logic [6:0] a, input logic [8:0] d);
		logic [15:0] q;
		xfer({a, 1'b0, 7'h00, d}, 24, q);
	endtask

	task automatic rd24(input logic [6:0] a, output logic [8:0] d);
		logic [15:0] q;
		xfer({a, 1'b1, 16'h0000}, 24, q);
		d = q[8:0];
	endtask
endmodule

// ===== sim/level_mute_tieoff_regs_tb_top.sv
// Self-checking bench for the level readout, automute and tie-off register slice.
`timescale 1ns/100ps
module level_mute_tieoff_regs_tb_top;
	logic       clk;
	logic       rst;
	logic       mode;
	logic       force4;
	logic       sel_n;
	logic       sclk;
	logic       sdio_h;
	logic       sdio_o;
	logic       sdio_oe;
	logic       wire_sdio;
	logic       dual;
	logic [8:0] ppl;
	logic [8:0] ppr;
	logic [8:0] pkl;
	logic [8:0] pkr;
	logic [4:0] st;
	logic [4:0] au;
	logic [1:0] boff;
	logic       tap;
	logic [4:0] cl;
	logic [8:0] r;
	int         bad_count;
	int         check_count;

	assign wire_sdio = sdio_oe ? sdio_o : sdio_h;

	serial_host u_host (.clk_i(clk), .line_i(wire_sdio), .sel_n_o(sel_n), .sclk_o(sclk),
		.sdio_o(sdio_h));

	level_mute_tieoff_regs u_dut (.CLK_SYS_I(clk), .RST_I(rst), .MODE_I(mode),
		.FORCE_FOUR_WIRE_PORT_I(force4), .PORT_SELECT_N_I(sel_n), .SCLK_I(sclk),
		.SDIO_I(wire_sdio), .SDIO_O(sdio_o), .SDIO_OE_O(sdio_oe), .DUAL_CHANNEL_I(dual),
		.PP_AMPLITUDE_LEFT_I(ppl), .PP_AMPLITUDE_RIGHT_I(ppr), .PEAK_AMPLITUDE_LEFT_I(pkl),
		.PEAK_AMPLITUDE_RIGHT_I(pkr), .LIMITER_OVER_I(st[0]), .DIGITAL_GAIN_ZERO_I(st[1]),
		.AUTOMUTE_ACTIVE_I(st[2]), .NOISE_GATE_HOLD_I(st[3]), .SPEAKER_SUPPLY_HIGH_I(st[4]),
		.AUTO_LINE_TIEOFF_I(au[0]), .AUTO_SPK_POS_TIEOFF_I(au[1]), .AUTO_SPK_NEG_TIEOFF_I(au[2]),
		.AUTO_UNITY_BYPASS_I(au[3]), .AUTO_BOOST_BYPASS_I(au[4]), .UNITY_BUFFER_OFF_I(boff[0]),
		.BOOST_BUFFER_OFF_I(boff[1]), .AUTOMUTE_TAP_SELECT_O(tap), .LINE_TIEOFF_CLOSE_O(cl[0]),
		.SPK_POS_TIEOFF_CLOSE_O(cl[1]), .SPK_NEG_TIEOFF_CLOSE_O(cl[2]),
		.UNITY_BYPASS_CLOSE_O(cl[3]), .BOOST_BYPASS_CLOSE_O(cl[4]));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic give_verdict();
		if (bad_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic t_reset();
		for (int a = 7'h4c; a <= 7'h4f; a++) begin
			u_host.rd24(a[6:0], r);
			chk("reset value", r, 9'h000);
		end
		chk("outputs at reset", {3'h0, tap, cl}, 9'h000);
	endtask

	task automatic t_levels();
		ppl = 9'h123;
		ppr = 9'h1ff;
		pkl = 9'h1a5;
		pkr = 9'h05a;
		u_host.rd24(7'h4c, r);
		chk("pp single", r, 9'h123);
		dual = 1'b1;
		u_host.rd24(7'h4c, r);
		chk("pp dual", r, 9'h1ff);
		u_host.rd24(7'h4d, r);
		chk("peak dual", r, 9'h1a5);
		u_host.wr24(7'h4d, 9'h0aa);
		u_host.rd24(7'h4d, r);
		chk("peak after write", r, 9'h1a5);
		pkr = 9'h1f0;
		u_host.rd24(7'h4d, r);
		chk("peak right", r, 9'h1f0);
		dual = 1'b0;
		u_host.rd24(7'h4d, r);
		chk("peak single", r, 9'h1a5);
	endtask

	task automatic t_status();
		int pos[5] = '{0, 2, 3, 4, 5};
		for (int i = 0; i < 5; i++) begin
			st = 5'h01 << i;
			u_host.rd24(7'h4e, r);
			chk("status bit", r, 9'h001 << pos[i]);
		end
		st = 5'h00;
	endtask

	task automatic t_mute();
		u_host.wr24(7'h4e, 9'h1ff);
		u_host.rd24(7'h4e, r);
		chk("automute reg", r, 9'h040);
		chk("tap select", {8'h00, tap}, 9'h001);
		u_host.wr24(7'h4e, 9'h000);
		chk("tap select", {8'h00, tap}, 9'h000);
	endtask

	task automatic t_override();
		au = 5'h1f;
		u_host.wr24(7'h4f, 9'h0f8);
		chk("override off", {4'h0, cl}, 9'h01f);
		u_host.wr24(7'h4f, 9'h100);
		chk("forced open", {4'h0, cl}, 9'h018);
		au = 5'h00;
		boff = 2'h3;
		u_host.wr24(7'h4f, 9'h1ff);
		chk("forced closed", {4'h0, cl}, 9'h01f);
		u_host.rd24(7'h4f, r);
		chk("override reg", r, 9'h1f8);
		boff = 2'h0;
		repeat (2) @(negedge clk);
		chk("buffers on", {4'h0, cl}, 9'h007);
	endtask

	task automatic t_port();
		logic [15:0] q;
		force4 = 1'b0;
		u_host.wr16(7'h4f, 9'h108);
		mode = 1'b0;
		u_host.wr16(7'h4f, 9'h1f8);
		mode = 1'b1;
		u_host.xfer({7'h00, 1'b0, 7'h4f, 9'h1f8}, 17, q);
		force4 = 1'b1;
		u_host.rd24(7'h4f, r);
		chk("short write", r, 9'h108);
	endtask

	task automatic t_rerun();
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		u_host.rd24(7'h4f, r);
		chk("override after reset", r, 9'h000);
		chk("switches after reset", {4'h0, cl}, 9'h000);
	endtask

	initial begin
		bad_count = 0;
		check_count = 0;
		rst = 1'b1;
		{mode, force4, dual, ppl, ppr, pkl, pkr, st, au, boff} = '0;
		mode = 1'b1;
		force4 = 1'b1;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		t_reset();
		t_levels();
		t_status();
		t_mute();
		t_override();
		t_port();
		t_rerun();
		give_verdict();
	end

	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		give_verdict();
	end
endmodule
